// [design/vpc_event_classifier.sv]
`timescale 1ns/1ns
`include "vpc_regs.svh"
module vpc_event_classifier
    import vpc_pkg::*;
#(
    parameter int LANES = 4,
    parameter int CW = 4,
    parameter bit COUNT_PREFIX = 1'b1,
    parameter bit COUNT_NARROW_STATE = 1'b1,
    parameter bit CRYPTO_AS_SIMD = 1'b1,
    parameter bit CRYPTO_AS_SCALAR = 1'b0,
    parameter bit SPEC_FROM_RETIRE = 1'b0
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic wide_state_i,
    input wire logic [LANES-1:0] ret_valid_i,
    input wire vpc_pkg::vpc_class_t [LANES-1:0] ret_class_i,
    input wire logic [LANES-1:0] ret_prefix_i,
    input wire logic [LANES-1:0] spec_valid_i,
    input wire vpc_pkg::vpc_class_t [LANES-1:0] spec_class_i,
    input wire logic [LANES-1:0] spec_prefix_i,
    input wire vpc_pkg::vpc_num_t [LANES-1:0] spec_num_i,
    input wire logic [LANES-1:0] uop_valid_i,
    input wire vpc_pkg::vpc_class_t [LANES-1:0] uop_class_i,
    input wire logic [LANES-1:0] uop_prefix_i,
    output logic [CW-1:0] vector_retired_instr_event_o,
    output logic [CW-1:0] vector_speculative_op_event_o,
    output logic [CW-1:0] micro_op_speculative_event_o,
    output logic [CW-1:0] packed_simd_micro_op_event_o,
    output logic [CW-1:0] vector_micro_op_event_o,
    output logic [CW-1:0] simd_or_vector_micro_op_event_o,
    output logic [CW-1:0] any_simd_micro_op_event_o,
    output logic [CW-1:0] vector_int_op_event_o,
    output logic [CW-1:0] vector_fp_op_event_o
);
    import vpc_pkg::*;

    localparam int NEV = 9;
    // Event numbers for the retired and speculative outputs, both inside the reserved block.
    localparam logic [15:0] EVT_RET = `VPC_EVT_RETIRED;
    localparam logic [15:0] EVT_SPC = `VPC_EVT_SPEC;

    logic [LANES-1:0] hit [NEV];
    logic [CW-1:0] sum [NEV];
    logic [CW-1:0] cnt_r [NEV];
    logic [LANES-1:0] sp_v;
    vpc_class_t sp_c [LANES];
    logic [LANES-1:0] sp_p;
    logic cnt_en;

    function automatic logic is_simd(input vpc_class_t c);
        logic r;
        r = (c == VPC_CLS_SIMD) || (c == VPC_CLS_SIMD_SCALAR);
        if (c == VPC_CLS_CRYPTO) begin
            r = CRYPTO_AS_SIMD;
        end
        return r;
    endfunction : is_simd

    // Narrow-state counting is a strap; the block reports nothing there if cleared.
    assign cnt_en = wide_state_i | COUNT_NARROW_STATE;

    // The pipeline's own speculation view is reused so the speculative, int and fp events agree with the base ones.
    always_comb begin
        for (int k = 0; k < LANES; k++) begin
            sp_v[k] = SPEC_FROM_RETIRE ? ret_valid_i[k] : spec_valid_i[k];
            sp_c[k] = SPEC_FROM_RETIRE ? ret_class_i[k] : spec_class_i[k];
            sp_p[k] = SPEC_FROM_RETIRE ? ret_prefix_i[k] : spec_prefix_i[k];
        end
    end

    always_comb begin
        for (int e = 0; e < NEV; e++) begin
            hit[e] = '0;
        end
        for (int k = 0; k < LANES; k++) begin
            // Load, store, prefetch and predicate ops arrive already tagged vector.
            hit[0][k] = ret_valid_i[k] && ret_class_i[k] == VPC_CLS_VECTOR
                && (COUNT_PREFIX || !ret_prefix_i[k]);
            hit[1][k] = sp_v[k] && sp_c[k] == VPC_CLS_VECTOR
                && (COUNT_PREFIX || !sp_p[k]);
            // Micro-ops are taken at issue, so squashed paths count too.
            hit[2][k] = uop_valid_i[k] && (COUNT_PREFIX || !uop_prefix_i[k]);
            hit[3][k] = hit[2][k] && is_simd(uop_class_i[k]);
            hit[4][k] = hit[2][k] && uop_class_i[k] == VPC_CLS_VECTOR;
            hit[5][k] = hit[3][k] || hit[4][k];
            hit[6][k] = hit[5][k] || (hit[2][k] && CRYPTO_AS_SCALAR
                && uop_class_i[k] == VPC_CLS_CRYPTO);
            // One number class per op, so int and fp can never both fire.
            hit[7][k] = hit[1][k] && spec_num_i[k] == VPC_NUM_INT;
            hit[8][k] = hit[1][k] && spec_num_i[k] == VPC_NUM_FP;
        end
    end

    // Unused recommended events are left out to save area.
    for (genvar e = 0; e < NEV; e++) begin : g_sum
        vpc_lane_sum #(.LANES(LANES), .CW(CW)) u_sum (
            .hit_i(hit[e]),
            .sum_o(sum[e])
        );
        always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                cnt_r[e] <= `VPC_CNT_RESET;
            end else begin
                cnt_r[e] <= cnt_en ? sum[e] : `VPC_CNT_RESET;
            end
        end
    end

    assign vector_retired_instr_event_o = cnt_r[0];
    assign vector_speculative_op_event_o = cnt_r[1];
    assign micro_op_speculative_event_o = cnt_r[2];
    assign packed_simd_micro_op_event_o = cnt_r[3];
    assign vector_micro_op_event_o = cnt_r[4];
    assign simd_or_vector_micro_op_event_o = cnt_r[5];
    assign any_simd_micro_op_event_o = cnt_r[6];
    assign vector_int_op_event_o = cnt_r[7];
    assign vector_fp_op_event_o = cnt_r[8];

    a_event_range: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        EVT_RET >= `VPC_EVT_RANGE_LO && EVT_SPC <= `VPC_EVT_RANGE_HI)
        else $error("Event number outside reserved block.");
    a_ret_count: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        cnt_en |=> vector_retired_instr_event_o == $past(sum[0]))
        else $error("Retired count mismatch.");
    a_int_fp_excl: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (hit[7] & hit[8]) == '0)
        else $error("Op flagged both int and fp.");
    a_uop_wrong_path: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (cnt_en && uop_valid_i != '0 && COUNT_PREFIX)
        |=> micro_op_speculative_event_o != '0)
        else $error("Issued micro-op not counted.");
    a_simd_subset: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        packed_simd_micro_op_event_o <= simd_or_vector_micro_op_event_o
        && simd_or_vector_micro_op_event_o <= micro_op_speculative_event_o)
        else $error("Micro-op event nesting broken.");
    a_spec_count: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (cnt_en && sp_v == '0) |=> vector_speculative_op_event_o == '0)
        else $error("Speculative count without ops.");
    a_narrow_off: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        !cnt_en |=> vector_retired_instr_event_o == '0 && vector_micro_op_event_o == '0)
        else $error("Counted while disabled.");
    a_prefix_drop: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (!COUNT_PREFIX && ret_valid_i == ret_prefix_i) |=> vector_retired_instr_event_o == '0)
        else $error("Prefix counted while excluded.");
    // While cnt_en is set, each event output is the lane sum registered one cycle earlier.
    a_spec_next: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        cnt_en |=> vector_speculative_op_event_o == $past(sum[1]))
        else $error("Speculative count mismatch.");
    a_uop_next: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        cnt_en |=> micro_op_speculative_event_o == $past(sum[2]))
        else $error("Micro-op count mismatch.");
    a_simd_next: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        cnt_en |=> packed_simd_micro_op_event_o == $past(sum[3]))
        else $error("Packed micro-op count mismatch.");
    a_vec_next: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        cnt_en |=> vector_micro_op_event_o == $past(sum[4]))
        else $error("Vector micro-op count mismatch.");
    a_union_next: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        cnt_en |=> simd_or_vector_micro_op_event_o == $past(sum[5]))
        else $error("Union micro-op count mismatch.");
    a_any_next: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        cnt_en |=> any_simd_micro_op_event_o == $past(sum[6]))
        else $error("Any micro-op count mismatch.");
    a_int_next: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        cnt_en |=> vector_int_op_event_o == $past(sum[7]))
        else $error("Integer op count mismatch.");
    a_fp_next: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        cnt_en |=> vector_fp_op_event_o == $past(sum[8]))
        else $error("Floating-point op count mismatch.");
    // A count can never exceed the number of lanes seen in one cycle.
    a_ret_cap: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        vector_retired_instr_event_o <= CW'(LANES))
        else $error("Retired count above lane total.");
    a_uop_cap: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        micro_op_speculative_event_o <= CW'(LANES))
        else $error("Micro-op count above lane total.");
    a_intfp_sum: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        vector_int_op_event_o + vector_fp_op_event_o <= vector_speculative_op_event_o)
        else $error("Int and fp counts exceed speculative count.");
    a_vec_in_uop: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        vector_micro_op_event_o <= micro_op_speculative_event_o)
        else $error("Vector micro-ops exceed all micro-ops.");
    c_spec_full: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
        vector_speculative_op_event_o == CW'(LANES));
    c_ret_full: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
        vector_retired_instr_event_o == CW'(LANES));
    c_int_fp: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
        vector_int_op_event_o != '0 && vector_fp_op_event_o != '0);
    c_simd_uop: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
        packed_simd_micro_op_event_o != '0);
endmodule : vpc_event_classifier

// [design/vpc_regs.svh]
`ifndef VPC_REGS_SVH
`define VPC_REGS_SVH
`define VPC_EVT_RANGE_LO 16'h8000
`define VPC_EVT_RANGE_HI 16'h80FF
`define VPC_EVT_RETIRED 16'h8002
`define VPC_EVT_SPEC 16'h8006
`define VPC_EVT_UOP 16'h8008
`define VPC_EVT_SIMD_UOP 16'h8009
`define VPC_EVT_VEC_UOP 16'h800A
`define VPC_EVT_BOTH_UOP 16'h800B
`define VPC_EVT_ANY_UOP 16'h800C
`define VPC_EVT_PFX_LO 16'h807C
`define VPC_EVT_PFX_HI 16'h807F
`define VPC_CNT_RESET 4'h0
`endif

// [design/vpc_pkg.sv]
package vpc_pkg;
    typedef enum logic [2:0] {
        VPC_CLS_OTHER,
        VPC_CLS_VECTOR,
        VPC_CLS_SIMD,
        VPC_CLS_SIMD_SCALAR,
        VPC_CLS_CRYPTO,
        VPC_CLS_MOVE
    } vpc_class_t;
    typedef enum logic [1:0] {
        VPC_NUM_NONE,
        VPC_NUM_INT,
        VPC_NUM_FP
    } vpc_num_t;
endpackage : vpc_pkg

// [design/vpc_lane_sum.sv]
`timescale 1ns/1ns
module vpc_lane_sum #(
    parameter int LANES = 4,
    parameter int CW = 4
) (
    input wire logic [LANES-1:0] hit_i,
    output logic [CW-1:0] sum_o
);
    always_comb begin
        sum_o = '0;
        for (int k = 0; k < LANES; k++) begin
            sum_o = sum_o + CW'(hit_i[k]);
        end
    end
endmodule : vpc_lane_sum

// [verif/vpc_pipe_model.sv]
`timescale 1ns/1ns
module vpc_pipe_model (
    input wire logic core_clk_i,
    input wire logic [2:0] cls_i,
    input wire logic [1:0] num_i,
    input wire logic [3:0] rv_i,
    input wire logic [3:0] sv_i,
    input wire logic [3:0] uv_i,
    output vpc_pkg::vpc_class_t [3:0] rc_o,
    output vpc_pkg::vpc_class_t [3:0] sc_o,
    output vpc_pkg::vpc_class_t [3:0] uc_o,
    output vpc_pkg::vpc_num_t [3:0] sn_o
);
    import vpc_pkg::*;
    // Idle lanes carry junk that moves every cycle, so ungated lanes show up.
    logic [2:0] junk_r = 3'h0;
    always_ff @(posedge core_clk_i) junk_r <= junk_r + 3'h1;
    for (genvar l = 0; l < 4; l++) begin : g_lane
        assign rc_o[l] = vpc_class_t'(rv_i[l] ? cls_i : junk_r);
        assign sc_o[l] = vpc_class_t'(sv_i[l] ? cls_i : junk_r);
        assign uc_o[l] = vpc_class_t'(uv_i[l] ? cls_i : junk_r);
        assign sn_o[l] = vpc_num_t'(sv_i[l] ? num_i : junk_r[1:0]);
    end
endmodule : vpc_pipe_model

// [verif/testbench.sv]
`timescale 1ns/1ns
module testbench;
    import vpc_pkg::*;
    typedef struct packed {logic [2:0] c; logic [1:0] n; logic [3:0] m;} vpc_row_t;
    logic clk = 1'b0, rst = 1'b1, wide = 1'b1;
    logic [2:0] cls = 3'h0;
    logic [1:0] num = 2'h0;
    logic [3:0] rv = 4'h0, sv = 4'h0, uv = 4'h0, pf = 4'h0;
    logic [3:0] o [9];
    vpc_class_t [3:0] rc, sc, uc;
    vpc_num_t [3:0] sn;
    int err_count = 0, total_checks = 0;
    vpc_row_t rows [7] = '{{3'h1, 2'h1, 4'hF}, {3'h1, 2'h2, 4'h5}, {3'h2, 2'h0, 4'hA},
        {3'h3, 2'h1, 4'h1}, {3'h4, 2'h2, 4'h6}, {3'h0, 2'h1, 4'hF}, {3'h0, 2'h0, 4'h0}};
    initial forever #5 clk = ~clk;
    vpc_pipe_model i_vpc_pipe_model (.core_clk_i(clk), .cls_i(cls), .num_i(num), .rv_i(rv),
        .sv_i(sv), .uv_i(uv), .rc_o(rc), .sc_o(sc), .uc_o(uc), .sn_o(sn));
    vpc_event_classifier i_vpc_event_classifier (.core_clk_i(clk), .sys_rst_i(rst),
        .wide_state_i(wide), .ret_valid_i(rv), .ret_class_i(rc), .ret_prefix_i(pf),
        .spec_valid_i(sv), .spec_class_i(sc), .spec_prefix_i(pf), .spec_num_i(sn),
        .uop_valid_i(uv), .uop_class_i(uc), .uop_prefix_i(pf),
        .vector_retired_instr_event_o(o[0]), .vector_speculative_op_event_o(o[1]),
        .micro_op_speculative_event_o(o[2]), .packed_simd_micro_op_event_o(o[3]),
        .vector_micro_op_event_o(o[4]), .simd_or_vector_micro_op_event_o(o[5]),
        .any_simd_micro_op_event_o(o[6]), .vector_int_op_event_o(o[7]),
        .vector_fp_op_event_o(o[8]));
    task automatic check(input string nm, input logic [3:0] seen, input logic [3:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic drive(input vpc_row_t r, input logic [3:0] rm, input logic [3:0] sm);
        cls <= r.c;
        num <= r.n;
        rv <= rm;
        sv <= sm;
        uv <= r.m;
    endtask : drive
    task automatic expect_all(input vpc_row_t r);
        logic [3:0] k;
        logic v;
        logic s;
        k = 4'($countones(r.m));
        v = (r.c == VPC_CLS_VECTOR);
        s = (r.c == VPC_CLS_SIMD) || (r.c == VPC_CLS_SIMD_SCALAR) || (r.c == VPC_CLS_CRYPTO);
        check("retired", o[0], v ? k : 4'h0);
        check("spec", o[1], v ? k : 4'h0);
        check("uop", o[2], k);
        check("simd_uop", o[3], s ? k : 4'h0);
        check("vec_uop", o[4], v ? k : 4'h0);
        check("both_uop", o[5], (v || s) ? k : 4'h0);
        check("any_uop", o[6], (v || s) ? k : 4'h0);
        check("int_op", o[7], (v && r.n == 2'h1) ? k : 4'h0);
        check("fp_op", o[8], (v && r.n == 2'h2) ? k : 4'h0);
    endtask : expect_all
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    initial begin
        repeat (20) @(posedge clk);
        for (int i = 0; i < 9; i++) check("reset", o[i], 4'h0);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            if (i < 7) drive(rows[i], rows[i].m, rows[i].m);
            #1;
            if (i > 0) expect_all(rows[i - 1]);
        end
        @(posedge clk);
        pf <= 4'hF;
        wide <= 1'b0;
        drive(rows[0], 4'h3, 4'h0);
        @(posedge clk);
        drive(rows[1], 4'h0, 4'hF);
        #1;
        check("narrow", o[0], 4'h2);
        check("spec_sep", o[1], 4'h0);
        check("prefix", o[2], 4'h4);
        @(posedge clk);
        #1;
        check("ret_sep", o[0], 4'h0);
        check("spec_fp", o[8], 4'h4);
        @(posedge clk);
        rst <= 1'b1;
        #1;
        check("midrst", o[2], 4'h0);
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        #1;
        check("after", o[0], 4'h0);
        conclude();
    end
    initial begin
        repeat (500) @(posedge clk);
        err_count++;
        conclude();
    end
endmodule : testbench
